// >>> icop_pkg.sv
/*
 * Constants, layouts and state types for the identification check and
 * reset option block. Assumes a single 25 MHz clock and AHB-Lite access.
 */
// How it works
// - Seven stored ID bytes at fixed vector tops
// - Serial mode skips check if reset vector blank
// - Tool commands accepted only after full match when check required
// - Any mismatch refuses all tool commands when check required
// - CPU bus writes cannot alter stored bytes; here bus writes can while flash_prog_en is set, unless ID gate locked in serial mode or protect on outside it
// - Option settings come from byte at 0ffff
// - Bit0 zero starts watchdog after reset
// - Protect needs qualify one and protect zero
// - Bit5 zero enables monitor0 reset after reset
// - Bit7 zero enables count source protection
// - Erase leaves option byte ff, defaults apply
package icop_pkg;

  // Register indices; byte address is four times the index
  localparam logic [15:0] ICOP_IDX_ID0 = 16'hffdf;
  localparam logic [15:0] ICOP_IDX_ID1 = 16'hffe3;
  localparam logic [15:0] ICOP_IDX_ID2 = 16'hffeb;
  localparam logic [15:0] ICOP_IDX_ID3 = 16'hffef;
  localparam logic [15:0] ICOP_IDX_ID4 = 16'hfff3;
  localparam logic [15:0] ICOP_IDX_ID5 = 16'hfff7;
  localparam logic [15:0] ICOP_IDX_ID6 = 16'hfffb;
  localparam logic [15:0] ICOP_IDX_RV0 = 16'hfffc;
  localparam logic [15:0] ICOP_IDX_RV1 = 16'hfffd;
  localparam logic [15:0] ICOP_IDX_RV2 = 16'hfffe;
  localparam logic [15:0] ICOP_IDX_OPT = 16'hffff;
  localparam logic [15:0] ICOP_IDX_CTRL = 16'h0000;
  localparam logic [15:0] ICOP_IDX_STAT = 16'h0001;

  // Storage slots
  localparam int ICOP_NSLOT = 11;
  localparam logic [3:0] ICOP_SLOT_RV0 = 4'h7;
  localparam logic [3:0] ICOP_SLOT_OPT = 4'ha;
  localparam logic [3:0] ICOP_SLOT_NONE = 4'hf;
  localparam logic [7:0] ICOP_ERASED = 8'hff;
  localparam logic [23:0] ICOP_RV_BLANK = 24'hffffff;

  // Option byte fields
  localparam int ICOP_OPT_WDT = 0;
  localparam int ICOP_OPT_QUAL = 2;
  localparam int ICOP_OPT_PROT = 3;
  localparam int ICOP_OPT_VMON = 5;
  localparam int ICOP_OPT_CSP = 7;

  // Control and status fields
  localparam int ICOP_CTRL_ERASE = 0;
  localparam int ICOP_CTRL_RESTART = 1;
  localparam int ICOP_ID_COUNT = 7;

  typedef enum logic [1:0] {
    ICOP_BUS_IDLE = 2'b00,
    ICOP_BUS_WAIT = 2'b01,
    ICOP_BUS_DONE = 2'b10
  } icop_bus_t;

  typedef struct packed {
    logic [2:0] cnt;
    logic bad;
    logic done;
  } icop_match_st_t;

  typedef struct packed {
    logic [ICOP_NSLOT-1:0][7:0] mem;
    icop_bus_t bus;
    logic dp_wr;
    logic [15:0] dp_idx;
    logic [31:0] rdata;
    logic [1:0] prog_s;
    logic [1:0] ser_s;
    logic [2:0] stb_s;
    logic [2:0] cmd_s;
    logic [7:0] byte_s1;
    logic [7:0] byte_s2;
    logic restart;
    logic ack;
    logic nak;
    logic loaded;
    logic wdt_auto;
    logic prot_on;
    logic vmon_en;
    logic csp_en;
  } icop_st_t;

endpackage

// >>> icop_match.sv
/*
 * Compares a stream of seven tool ID bytes against the stored ID bytes.
 * Assumes byte strobes are already in the hclk domain.
 */
module icop_match
  import icop_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic restart,
  input wire logic byte_vld,
  input wire logic [7:0] byte_in,
  input wire logic [ICOP_ID_COUNT-1:0][7:0] stored,
  output logic id_done,
  output logic id_ok
);

  icop_match_st_t st_r;
  icop_match_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (restart) begin
      st_nxt = '0;
    end else if (byte_vld && !st_r.done) begin
      if (byte_in != stored[st_r.cnt]) begin
        st_nxt.bad = 1'b1;
      end
      if (st_r.cnt == 3'(ICOP_ID_COUNT - 1)) begin
        st_nxt.done = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign id_done = st_r.done;
  assign id_ok = st_r.done && !st_r.bad;

  chk_mismatch_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    st_r.bad && !restart |=> st_r.bad)
    else $error("mismatch flag dropped without restart");

endmodule

// >>> icop_top.sv
/*
 * Flash vector area model holding the ID bytes, reset vector top bytes and
 * the reset option byte, with the tool ID gate and option decode.
 * Assumes an AHB-Lite master on hclk and tool pins from another domain.
 */
module icop_top
  import icop_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [17:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic flash_prog_en,
  input wire logic serial_mode,
  input wire logic tool_byte_stb,
  input wire logic [7:0] tool_byte,
  input wire logic tool_cmd_stb,
  output logic tool_cmd_ack,
  output logic tool_cmd_nak,
  output logic wdt_auto_start,
  output logic parallel_protect_on,
  output logic volt_monitor0_reset_en,
  output logic count_source_protect_en
);

  icop_st_t st_r;
  icop_st_t st_nxt;
  logic id_done;
  logic id_ok;
  logic cmp_req;
  logic byte_vld;
  logic cmd_vld;
  logic unlocked;
  logic wr_ok;
  logic addr_ph;
  logic [3:0] dp_slot;
  logic [7:0] opt;
  logic [ICOP_ID_COUNT-1:0][7:0] ids;

  ////////////////////////////////////////////////////////////////////////////
  // Storage decode

  function automatic logic [3:0] slot_of(input logic [15:0] idx);
    case (idx)
      ICOP_IDX_ID0: slot_of = 4'h0;
      ICOP_IDX_ID1: slot_of = 4'h1;
      ICOP_IDX_ID2: slot_of = 4'h2;
      ICOP_IDX_ID3: slot_of = 4'h3;
      ICOP_IDX_ID4: slot_of = 4'h4;
      ICOP_IDX_ID5: slot_of = 4'h5;
      ICOP_IDX_ID6: slot_of = 4'h6;
      ICOP_IDX_RV0: slot_of = 4'h7;
      ICOP_IDX_RV1: slot_of = 4'h8;
      ICOP_IDX_RV2: slot_of = 4'h9;
      ICOP_IDX_OPT: slot_of = ICOP_SLOT_OPT;
      default: slot_of = ICOP_SLOT_NONE;
    endcase
  endfunction

  assign ids = st_r.mem[ICOP_ID_COUNT-1:0];
  assign opt = st_r.mem[ICOP_SLOT_OPT];
  assign dp_slot = slot_of(st_r.dp_idx);

  // Check needed only in serial mode with a programmed reset vector
  assign cmp_req = st_r.ser_s[1] &&
    ({st_r.mem[9], st_r.mem[8], st_r.mem[7]} != ICOP_RV_BLANK);
  assign unlocked = !cmp_req || id_ok;

  // Only the flash programming path may change stored bytes
  assign wr_ok = st_r.prog_s[1] &&
    (st_r.ser_s[1] ? unlocked : !st_r.prot_on);

  assign byte_vld = st_r.stb_s[1] && !st_r.stb_s[2];
  assign cmd_vld = st_r.cmd_s[1] && !st_r.cmd_s[2];
  assign addr_ph = hsel && htrans[1] && hready;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_nxt = st_r;
    st_nxt.restart = 1'b0;
    st_nxt.ack = 1'b0;
    st_nxt.nak = 1'b0;
    st_nxt.prog_s = {st_r.prog_s[0], flash_prog_en};
    st_nxt.ser_s = {st_r.ser_s[0], serial_mode};
    st_nxt.stb_s = {st_r.stb_s[1:0], tool_byte_stb};
    st_nxt.cmd_s = {st_r.cmd_s[1:0], tool_cmd_stb};
    st_nxt.byte_s1 = tool_byte;
    st_nxt.byte_s2 = st_r.byte_s1;

    if (cmd_vld) begin
      st_nxt.ack = unlocked;
      st_nxt.nak = !unlocked;
    end

    // Options are caught once after a hardware reset release
    if (!st_r.loaded) begin
      st_nxt.loaded = 1'b1;
      st_nxt.wdt_auto = !opt[ICOP_OPT_WDT];
      st_nxt.prot_on = opt[ICOP_OPT_QUAL] && !opt[ICOP_OPT_PROT];
      st_nxt.vmon_en = !opt[ICOP_OPT_VMON];
      st_nxt.csp_en = !opt[ICOP_OPT_CSP];
    end

    case (st_r.bus)
      ICOP_BUS_IDLE: begin
        if (addr_ph) begin
          st_nxt.bus = ICOP_BUS_WAIT;
          st_nxt.dp_wr = hwrite;
          st_nxt.dp_idx = haddr[17:2];
        end
      end
      ICOP_BUS_WAIT: begin
        st_nxt.bus = ICOP_BUS_DONE;
        st_nxt.rdata = '0;
        if (st_r.dp_wr) begin
          if (dp_slot != ICOP_SLOT_NONE && wr_ok) begin
            st_nxt.mem[dp_slot] = hwdata[7:0];
          end
          if (st_r.dp_idx == ICOP_IDX_CTRL) begin
            st_nxt.restart = hwdata[ICOP_CTRL_RESTART];
            if (hwdata[ICOP_CTRL_ERASE] && wr_ok) begin
              st_nxt.mem = {ICOP_NSLOT{ICOP_ERASED}};
            end
          end
        end else if (dp_slot != ICOP_SLOT_NONE) begin
          st_nxt.rdata = {24'h000000, st_r.mem[dp_slot]};
        end else if (st_r.dp_idx == ICOP_IDX_STAT) begin
          st_nxt.rdata = {23'h000000, st_r.loaded, st_r.csp_en, st_r.vmon_en,
            st_r.prot_on, st_r.wdt_auto, id_done && !id_ok, id_ok, cmp_req};
        end
      end
      ICOP_BUS_DONE: begin
        st_nxt.bus = ICOP_BUS_IDLE;
        if (addr_ph) begin
          st_nxt.bus = ICOP_BUS_WAIT;
          st_nxt.dp_wr = hwrite;
          st_nxt.dp_idx = haddr[17:2];
        end
      end
      default: st_nxt.bus = ICOP_BUS_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
      st_r.mem <= {ICOP_NSLOT{ICOP_ERASED}};
      st_r.wdt_auto <= 1'b0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  icop_match u_match (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .restart(st_r.restart),
    .byte_vld(byte_vld),
    .byte_in(st_r.byte_s2),
    .stored(ids),
    .id_done(id_done),
    .id_ok(id_ok)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign hrdata = st_r.rdata;
  assign hreadyout = (st_r.bus != ICOP_BUS_WAIT);
  assign hresp = 1'b0;
  assign tool_cmd_ack = st_r.ack;
  assign tool_cmd_nak = st_r.nak;
  assign wdt_auto_start = st_r.wdt_auto;
  assign parallel_protect_on = st_r.prot_on;
  assign volt_monitor0_reset_en = st_r.vmon_en;
  assign count_source_protect_en = st_r.csp_en;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_cmd_refused: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && cmd_vld && cmp_req && !id_ok |=> tool_cmd_nak && !tool_cmd_ack)
    else $error("command not refused after failed ID check");

  chk_cmd_accepted: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && cmd_vld && (!cmp_req || id_ok) |=> tool_cmd_ack && !tool_cmd_nak)
    else $error("command not accepted when unlocked");

  chk_blank_skips: assert property (@(posedge hclk) disable iff (!hresetn)
    ({st_r.mem[9], st_r.mem[8], st_r.mem[7]} == ICOP_RV_BLANK) |-> !cmp_req)
    else $error("ID check required with blank reset vector");

  chk_no_cpu_write: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && !st_r.prog_s[1] |=> st_r.mem == $past(st_r.mem))
    else $error("stored bytes changed outside programming");

  chk_wdt_decode: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && !st_r.loaded |=> wdt_auto_start == !$past(opt[ICOP_OPT_WDT]))
    else $error("watchdog start decode wrong");

  chk_prot_decode: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && !st_r.loaded |=> parallel_protect_on ==
      ($past(opt[ICOP_OPT_QUAL]) && !$past(opt[ICOP_OPT_PROT])))
    else $error("protect decode wrong");

  chk_vmon_decode: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && !st_r.loaded |=> volt_monitor0_reset_en == !$past(opt[ICOP_OPT_VMON]))
    else $error("monitor start decode wrong");

  chk_csp_decode: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && !st_r.loaded |=> count_source_protect_en == !$past(opt[ICOP_OPT_CSP]))
    else $error("count source decode wrong");

  chk_opt_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    st_r.loaded |=> $stable(volt_monitor0_reset_en) && $stable(wdt_auto_start))
    else $error("options changed without hardware reset");

  chk_erase_ff: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && st_r.bus == ICOP_BUS_WAIT && st_r.dp_wr && st_r.dp_idx == ICOP_IDX_CTRL &&
    hwdata[ICOP_CTRL_ERASE] && wr_ok |=> opt == ICOP_ERASED)
    else $error("erase did not leave option byte ff");

  chk_bus_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && addr_ph && st_r.bus != ICOP_BUS_WAIT |=> !hreadyout ##1 hreadyout)
    else $error("bus answer not one wait state");

  cov_cmd_ack: cover property (@(posedge hclk) disable iff (!hresetn) tool_cmd_ack);
  cov_cmd_nak: cover property (@(posedge hclk) disable iff (!hresetn) tool_cmd_nak);
  cov_erase: cover property (@(posedge hclk) disable iff (!hresetn)
    st_r.loaded && opt == ICOP_ERASED && st_r.prog_s[1]);
  cov_id_ok: cover property (@(posedge hclk) disable iff (!hresetn) cmp_req && id_ok);

endmodule

// >>> icop_tool.sv
/*
 * Serial programmer model driving the tool pins of the ID gate.
 * Assumes its tasks are called right after a rising hclk edge.
 */
module icop_tool (
  input wire logic hclk,
  output logic tool_byte_stb,
  output logic [7:0] tool_byte,
  output logic tool_cmd_stb,
  input wire logic tool_cmd_ack,
  input wire logic tool_cmd_nak
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    tool_byte_stb = 1'b0;
    tool_cmd_stb = 1'b0;
    tool_byte = 8'h00;
  end

  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // Byte held around the strobe, then inverted once released
  task automatic send_id(input logic [7:0] b);
    tool_byte <= b;
    idle(1);
    tool_byte_stb <= 1'b1;
    idle(5);
    tool_byte_stb <= 1'b0;
    idle(1);
    tool_byte <= ~b;
    idle(4);
  endtask

  task automatic send_cmd(output logic ack, output logic nak);
    ack = 1'b0;
    nak = 1'b0;
    tool_cmd_stb <= 1'b1;
    repeat (10) begin
      @(negedge hclk);
      ack |= (tool_cmd_ack === 1'b1);
      nak |= (tool_cmd_nak === 1'b1);
    end
    @(posedge hclk);
    tool_cmd_stb <= 1'b0;
    idle(5);
  endtask
endmodule

// >>> icop_top_tb.sv
/*
 * Self-checking bench for the ID gate and option byte block.
 * Assumes one AHB-Lite master, the tool model and a 25 MHz clock.
 */
module icop_top_tb;
  import icop_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [15:0] idx;
    logic [7:0] wd;
    logic prog;
    logic [7:0] exp;
  } icop_row_t;

  logic hclk = 1'b0;
  logic hresetn, ce, hsel, hwrite, flash_prog_en, serial_mode;
  logic [17:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd_s;
  logic hreadyout, hresp, byte_stb, cmd_stb, ack, nak;
  logic wdt, prot, vmon, csp;
  logic [7:0] tbyte;
  logic [3:0] opts;
  int err_count = 0;
  int n_checks = 0;

  icop_row_t rows [11] = '{
    '{ICOP_IDX_ID0, 8'h11, 1'b1, 8'h11},
    '{ICOP_IDX_ID1, 8'h22, 1'b1, 8'h22},
    '{ICOP_IDX_ID2, 8'h33, 1'b1, 8'h33},
    '{ICOP_IDX_ID3, 8'h44, 1'b1, 8'h44},
    '{ICOP_IDX_ID4, 8'h55, 1'b1, 8'h55},
    '{ICOP_IDX_ID5, 8'h66, 1'b1, 8'h66},
    '{ICOP_IDX_ID6, 8'h77, 1'b1, 8'h77},
    '{ICOP_IDX_RV0, 8'h00, 1'b1, 8'h00},
    '{ICOP_IDX_ID0, 8'h99, 1'b0, 8'h11},
    '{ICOP_IDX_OPT, 8'h52, 1'b1, 8'h52},
    '{16'h0100, 8'h5a, 1'b1, 8'h00}
  };

  always #20 hclk = ~hclk;
  assign opts = {wdt, prot, vmon, csp};

  icop_top uut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .flash_prog_en(flash_prog_en), .serial_mode(serial_mode),
    .tool_byte_stb(byte_stb), .tool_byte(tbyte), .tool_cmd_stb(cmd_stb),
    .tool_cmd_ack(ack), .tool_cmd_nak(nak), .wdt_auto_start(wdt),
    .parallel_protect_on(prot), .volt_monitor0_reset_en(vmon),
    .count_source_protect_en(csp)
  );

  icop_tool tool (
    .hclk(hclk), .tool_byte_stb(byte_stb), .tool_byte(tbyte),
    .tool_cmd_stb(cmd_stb), .tool_cmd_ack(ack), .tool_cmd_nak(nak)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // Ready sampled mid-cycle, away from the launching edge
  task automatic wait_rdy();
    int n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    rd_s = hrdata;
    if (n >= 20) begin
      err_count++;
      summarize();
    end
    @(posedge hclk);
  endtask

  task automatic ahb(input logic w, input logic [15:0] idx, input logic [7:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {idx, 2'b00};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h000000, wd};
    wait_rdy();
  endtask

  task automatic rdchk(input string what, input logic [15:0] idx, input logic [31:0] exp);
    ahb(1'b0, idx, 8'h00);
    chk(what, rd_s, exp);
  endtask

  task automatic cmd(input logic exp_ack);
    logic a, k;
    tool.send_cmd(a, k);
    chk("tool answer", {30'h0, a, k}, exp_ack ? 32'h2 : 32'h1);
  endtask

  task automatic settle();
    repeat (5) @(posedge hclk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    hresetn = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    haddr = 18'h00000;
    hwdata = 32'h00000000;
    flash_prog_en = 1'b0;
    serial_mode = 1'b0;
    repeat (8) @(posedge hclk);
    chk("reset outputs", {hreadyout, hresp, ack, nak, opts}, 32'h80);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    chk("options", opts, 32'h0);
    rdchk("status", ICOP_IDX_STAT, 32'h80);
    serial_mode <= 1'b1;
    settle();
    cmd(1'b1);
    serial_mode <= 1'b0;
    foreach (rows[i]) begin
      flash_prog_en <= rows[i].prog;
      settle();
      ahb(1'b1, rows[i].idx, rows[i].wd);
      rdchk("stored byte", rows[i].idx, {24'h000000, rows[i].exp});
    end
    chk("options kept", opts, 32'h0);
    flash_prog_en <= 1'b0;
    serial_mode <= 1'b1;
    settle();
    rdchk("status", ICOP_IDX_STAT, 32'h81);
    cmd(1'b0);
    for (int i = 0; i < ICOP_ID_COUNT; i++)
      tool.send_id(rows[i].wd);
    cmd(1'b1);
    cmd(1'b1);
    flash_prog_en <= 1'b1;
    settle();
    ahb(1'b1, ICOP_IDX_CTRL, 8'h02);
    for (int i = 0; i < ICOP_ID_COUNT; i++)
      tool.send_id(i == 3 ? 8'h00 : rows[i].wd);
    cmd(1'b0);
    rdchk("status", ICOP_IDX_STAT, 32'h85);
    ahb(1'b1, ICOP_IDX_ID0, 8'haa);
    rdchk("locked id", ICOP_IDX_ID0, 32'h11);
    serial_mode <= 1'b0;
    settle();
    ahb(1'b1, ICOP_IDX_CTRL, 8'h01);
    rdchk("erased id", ICOP_IDX_ID6, 32'hff);
    rdchk("erased option", ICOP_IDX_OPT, 32'hff);
    serial_mode <= 1'b1;
    settle();
    cmd(1'b1);
    hresetn <= 1'b0;
    @(negedge hclk);
    chk("second reset", {hreadyout, hresp, ack, nak, opts}, 32'h80);
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    settle();
    chk("options", opts, 32'h0);
    summarize();
  end
endmodule
